// File: design/mps_pkg.sv
package mps_pkg;

	// =====================================================
	// Timing
	// =====================================================
	localparam int          CLK_HZ          = 20000000;
	localparam int          CYC_W           = 16;
	localparam logic [15:0] CYCLE_LEN_RST   = 16'h03E8;
	localparam int          SEL_SETUP_NS    = 1000;
	localparam int          SEL_SETUP_CYC   = (SEL_SETUP_NS * (CLK_HZ / 1000000) + 999) / 1000;

	// =====================================================
	// Current balance
	// =====================================================
	localparam int          CUR_W           = 12;
	localparam int          WID_W           = 16;
	localparam int          FILT_SHIFT      = 3;
	localparam int          GAIN_SHIFT      = 2;

	typedef enum logic [1:0] {
		MPS_CH_TWO,
		MPS_CH_THREE,
		MPS_CH_FOUR
	} mps_chan_e;

endpackage : mps_pkg

// File: design/mps_sequencer.sv
`timescale 1ns/1ps
// Contract
// - Strap levels pick two, three or four channels
// - Cycle spans successive pulse starts, period programmed
// - Four channels: pulses spaced quarter cycle apart
// - Ch4 strap high, ch3 strap low: three channels, third spacing
// - Ch3 strap high: two channels, half spacing
// - Sample active channels each cycle, idle others
// - Average equals sum over active channel count
// - Filtered error trims each channel pulse width
// - Enable low: both regulators off, sample select
// - Capture select level on enable rising edge
// - Low means serial mode, high parallel mode
// - Parallel mode keeps bridge regulator disabled
module mps_sequencer (
	input  wire logic                      i_mclk,
	input  wire logic                      i_rst_n,
	input  wire logic                      i_enable,
	input  wire logic                      i_iface_mode_select_pin,
	input  wire logic                      i_ch3_sense_neg_strap,
	input  wire logic                      i_ch4_sense_neg_strap,
	input  wire logic [15:0]               i_cycle_len,
	input  wire logic [15:0]               i_error_amp_level,
	input  wire logic [4*mps_pkg::CUR_W-1:0] i_sense_current,
	output logic                           o_phase_pulse_one,
	output logic                           o_phase_pulse_two,
	output logic                           o_phase_pulse_three,
	output logic                           o_phase_pulse_four,
	output logic [3:0]                     o_sense_active,
	output logic                           o_core_enable,
	output logic                           o_bridge_enable,
	output logic                           o_serial_vid_mode,
	output logic                           o_parallel_vid_mode,
	output logic [mps_pkg::CUR_W-1:0]      o_cycle_average_current,
	output logic [1:0]                     o_chan_count
);

	// =====================================================
	// Input synchronisers
	// =====================================================
	logic [3:0] sync1;
	logic [3:0] sync2;
	logic       en_q;
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
			en_q  <= 1'b0;
		end else begin
			sync1 <= {i_enable, i_iface_mode_select_pin, i_ch3_sense_neg_strap, i_ch4_sense_neg_strap};
			sync2 <= sync1;
			en_q  <= sync2[3];
		end
	end
	wire en_s   = sync2[3];
	wire sel_s  = sync2[2];
	wire s3     = sync2[1];
	wire s4     = sync2[0];

	// =====================================================
	// Mode latch and channel detection
	// =====================================================
	mps_pkg::mps_chan_e chans;
	mps_pkg::mps_chan_e next_chans;
	logic               sel_live;
	logic               next_sel_live;
	logic               mode_par;
	logic               next_mode_par;
	always_comb begin
		next_sel_live = sel_live;
		next_mode_par = mode_par;
		next_chans    = chans;
		if (!en_s) begin
			next_sel_live = sel_s;
			if (s3)
				next_chans = mps_pkg::MPS_CH_TWO;
			else if (s4)
				next_chans = mps_pkg::MPS_CH_THREE;
			else
				next_chans = mps_pkg::MPS_CH_FOUR;
		end
		if (en_s && !en_q)
			next_mode_par = sel_live;
	end
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			sel_live <= 1'b0;
			mode_par <= 1'b0;
			chans    <= mps_pkg::MPS_CH_FOUR;
		end else begin
			sel_live <= next_sel_live;
			mode_par <= next_mode_par;
			chans    <= next_chans;
		end
	end

	// =====================================================
	// Cycle timebase
	// =====================================================
	function automatic logic [1:0] nch_m1(input mps_pkg::mps_chan_e c);
		case (c)
			mps_pkg::MPS_CH_TWO:   nch_m1 = 2'd1;
			mps_pkg::MPS_CH_THREE: nch_m1 = 2'd2;
			default:               nch_m1 = 2'd3;
		endcase
	endfunction : nch_m1

	logic [15:0] cnt;
	logic [15:0] next_cnt;
	logic [1:0]  slot;
	logic [1:0]  next_slot;
	logic [15:0] slot_len;
	wire  [1:0]  last_slot = nch_m1(chans);
	wire         run = en_s && en_q;
	always_comb begin
		case (chans)
			mps_pkg::MPS_CH_TWO:   slot_len = i_cycle_len >> 1;
			mps_pkg::MPS_CH_THREE: slot_len = 16'((32'(i_cycle_len) * 32'd21846) >> 16);
			default:               slot_len = i_cycle_len >> 2;
		endcase
		next_cnt  = cnt;
		next_slot = slot;
		if (!run) begin
			next_cnt  = 16'h0000;
			next_slot = 2'h0;
		end else if (cnt + 16'h0001 >= slot_len) begin
			next_cnt  = 16'h0000;
			next_slot = (slot == last_slot) ? 2'h0 : slot + 2'h1;
		end else
			next_cnt = cnt + 16'h0001;
	end
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			cnt  <= 16'h0000;
			slot <= 2'h0;
		end else begin
			cnt  <= next_cnt;
			slot <= next_slot;
		end
	end
	wire slot_start = run && (cnt == 16'h0000);
	wire cyc_end    = run && (next_cnt == 16'h0000) && (slot == last_slot);

	// =====================================================
	// Current balance and pulse generation
	// =====================================================
	logic [mps_pkg::CUR_W-1:0] samp [4];
	logic [mps_pkg::CUR_W-1:0] avg;
	logic [mps_pkg::CUR_W-1:0] next_avg;
	logic signed [17:0]        filt [4];
	logic signed [17:0]        next_filt [4];
	logic [3:0]                pulse;
	logic [3:0]                next_pulse;
	logic [3:0]                act;
	logic [15:0]               width [4];
	logic [mps_pkg::CUR_W+1:0] sum;
	always_comb begin
		act = (chans == mps_pkg::MPS_CH_TWO) ? 4'h3 :
			(chans == mps_pkg::MPS_CH_THREE) ? 4'h7 : 4'hF;
		sum = '0;
		for (int i = 0; i < 4; i++)
			if (act[i])
				sum = sum + (mps_pkg::CUR_W+2)'(samp[i]);
		next_avg = avg;
		if (cyc_end)
			next_avg = mps_pkg::CUR_W'(sum / ({2'b00, last_slot} + 4'h1));
	end
	generate
		for (genvar g = 0; g < 4; g++) begin : g_ch
			// Channel g fires in slot (last - g) so ch1 fires last in the cycle
			wire [1:0] my_slot = last_slot - 2'(g);
			// Error is taken against the average of the same cycle's samples
			wire signed [17:0] err   = $signed({6'h00, next_avg}) - $signed({6'h00, samp[g]});
			wire signed [17:0] diff  = err - filt[g];
			wire signed [17:0] step  = diff >>> mps_pkg::FILT_SHIFT;
			// A step that truncates to zero still moves one count, so no offset is left behind
			wire signed [17:0] nudge = (step != 18'sh00000) ? step :
				(diff == 18'sh00000) ? 18'sh00000 : (diff[17] ? 18'sh3FFFF : 18'sh00001);
			always_comb begin
				next_filt[g] = filt[g];
				if (cyc_end && act[g])
					next_filt[g] = filt[g] + nudge;
				width[g] = 16'(i_error_amp_level + 16'(filt[g] >>> mps_pkg::GAIN_SHIFT));
				next_pulse[g] = 1'b0;
				if (run && act[g] && slot == my_slot && cnt < width[g] && cnt < slot_len)
					next_pulse[g] = 1'b1;
			end
			always_ff @(posedge i_mclk) begin
				if (!i_rst_n) begin
					filt[g]  <= '0;
					samp[g]  <= '0;
					pulse[g] <= 1'b0;
				end else begin
					filt[g]  <= next_filt[g];
					pulse[g] <= next_pulse[g];
					if (slot_start && slot == my_slot && act[g])
						samp[g] <= i_sense_current[g*mps_pkg::CUR_W +: mps_pkg::CUR_W];
				end
			end
		end
	endgenerate

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			avg                     <= '0;
			o_phase_pulse_one       <= 1'b0;
			o_phase_pulse_two       <= 1'b0;
			o_phase_pulse_three     <= 1'b0;
			o_phase_pulse_four      <= 1'b0;
			o_sense_active          <= 4'h0;
			o_core_enable           <= 1'b0;
			o_bridge_enable         <= 1'b0;
			o_serial_vid_mode       <= 1'b0;
			o_parallel_vid_mode     <= 1'b0;
			o_cycle_average_current <= '0;
			o_chan_count            <= 2'h0;
		end else begin
			avg                     <= next_avg;
			o_phase_pulse_one       <= pulse[0];
			o_phase_pulse_two       <= pulse[1];
			o_phase_pulse_three     <= pulse[2];
			o_phase_pulse_four      <= pulse[3];
			o_sense_active          <= run ? act : 4'h0;
			o_core_enable           <= run;
			o_bridge_enable         <= run && !mode_par;
			o_serial_vid_mode       <= run && !mode_par;
			o_parallel_vid_mode     <= run && mode_par;
			o_cycle_average_current <= avg;
			o_chan_count            <= last_slot;
		end
	end

	// =====================================================
	// Checks
	// =====================================================
	a_off_when_low: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		!en_s |=> !o_core_enable && !o_bridge_enable) else $error("regulator on while disabled");
	a_mode_capture: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		en_s && !en_q |=> mode_par == $past(sel_live)) else $error("mode not captured");
	a_mode_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		en_s && en_q |=> $stable(mode_par)) else $error("mode changed while enabled");
	a_bridge_par: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		o_parallel_vid_mode |-> !o_bridge_enable) else $error("bridge on in parallel");
	a_mode_excl: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		!(o_serial_vid_mode && o_parallel_vid_mode)) else $error("both modes");
	a_two_ch: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		!en_s && s3 |=> chans == mps_pkg::MPS_CH_TWO) else $error("two channel detect");
	a_three_ch: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		!en_s && !s3 && s4 |=> chans == mps_pkg::MPS_CH_THREE) else $error("three channel detect");
	a_idle_chan: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		chans == mps_pkg::MPS_CH_TWO |=> !o_phase_pulse_three && !o_phase_pulse_four && !o_sense_active[3])
		else $error("idle channel active");
	a_slot_wrap: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		run && slot > last_slot |-> 1'b0) else $error("slot out of range");
	a_avg_upd: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		!cyc_end |=> $stable(avg)) else $error("average changed mid cycle");

endmodule : mps_sequencer

// File: dv/mps_gate_drv_model.sv
`timescale 1ns/1ps
module mps_gate_drv_model (
	input wire logic       i_mclk,
	input wire logic [3:0] i_pulse
);
	// =====================================================
	// Per-phase edge timing seen by the gate drivers
	// =====================================================
	int         cyc = 0;
	int         rise[4];
	int         per[4];
	int         wid[4];
	int         hi[4];
	int         cnt[4];
	logic [3:0] prev = 4'h0;

	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		prev <= i_pulse;
		for (int k = 0; k < 4; k++) begin
			if (i_pulse[k] && !prev[k]) begin
				per[k] <= cyc - rise[k];
				rise[k] <= cyc;
				cnt[k] <= cnt[k] + 1;
			end
			hi[k] <= i_pulse[k] ? hi[k] + 1 : 0;
			if (!i_pulse[k] && prev[k])
				wid[k] <= hi[k];
		end
	end
endmodule : mps_gate_drv_model

// File: dv/tb_mps_sequencer.sv
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
	$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_mps_sequencer;
	logic                          mclk = 1'b0;
	logic                          rst_n = 1'b0;
	logic                          en = 1'b0;
	logic                          sel = 1'b0;
	logic                          s3 = 1'b0;
	logic                          s4 = 1'b0;
	logic [15:0]                   len = 16'h0028;
	logic [15:0]                   amp = 16'h0003;
	logic [4*mps_pkg::CUR_W-1:0]   cur = {4{12'h064}};
	logic [3:0]                    pls;
	logic [3:0]                    act;
	logic                          core;
	logic                          bridge;
	logic                          ser;
	logic                          par;
	logic [mps_pkg::CUR_W-1:0]     avg;
	logic [1:0]                    chn;
	int                            miscompares = 0;
	int                            samples_checked = 0;
	int                            c3;
	int                            c4;

	always #25 mclk = ~mclk;

	mps_sequencer u_dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_enable(en), .i_iface_mode_select_pin(sel),
		.i_ch3_sense_neg_strap(s3), .i_ch4_sense_neg_strap(s4), .i_cycle_len(len),
		.i_error_amp_level(amp), .i_sense_current(cur), .o_phase_pulse_one(pls[0]),
		.o_phase_pulse_two(pls[1]), .o_phase_pulse_three(pls[2]), .o_phase_pulse_four(pls[3]),
		.o_sense_active(act), .o_core_enable(core), .o_bridge_enable(bridge), .o_serial_vid_mode(ser),
		.o_parallel_vid_mode(par), .o_cycle_average_current(avg), .o_chan_count(chn));

	mps_gate_drv_model u_drv (.i_mclk(mclk), .i_pulse(pls));

	// =====================================================
	// Helpers
	// =====================================================
	task automatic cw(input int n);
		repeat (n) @(posedge mclk);
		#5;
	endtask : cw

	function automatic int dif(input int a, input int b, input int l);
		return ((a - b) % l + l) % l;
	endfunction : dif

	task automatic wait_core(input logic v);
		int k;
		k = 0;
		while (core !== v && k < 20) begin
			cw(1);
			k++;
		end
		if (core !== v) begin
			miscompares++;
			finish_test();
		end
	endtask : wait_core

	task automatic run(input logic m, input logic t3, input logic t4, input int l);
		sel = m;
		s3 = t3;
		s4 = t4;
		len = l[15:0];
		cw(25);
		en = 1'b1;
		wait_core(1'b1);
	endtask : run

	task automatic stop();
		en = 1'b0;
		wait_core(1'b0);
		`CHK(bridge, 1'b0)
		cw(3);
		c3 = u_drv.cnt[0];
		cw(100);
		`CHK(u_drv.cnt[0], c3)
	endtask : stop

	// =====================================================
	// Scenarios
	// =====================================================
	task automatic t_four();
		run(1'b0, 1'b0, 1'b0, 40);
		cw(200);
		`CHK(dif(u_drv.rise[2], u_drv.rise[3], 40), 10)
		`CHK(dif(u_drv.rise[1], u_drv.rise[2], 40), 10)
		`CHK(dif(u_drv.rise[0], u_drv.rise[1], 40), 10)
		`CHK(u_drv.per[0], 40)
		`CHK(u_drv.wid[3], 3)
		`CHK(chn, 2'h3)
		`CHK(act, 4'hF)
		`CHK(avg, 12'h064)
		`CHK({ser, par, bridge}, 3'b101)
		sel = 1'b1;
		s4 = 1'b1;
		cw(60);
		`CHK({ser, par}, 2'b10)
		`CHK(chn, 2'h3)
		stop();
	endtask : t_four

	task automatic t_three();
		cur = {12'hFA0, 12'h08C, 12'h064, 12'h03C};
		amp = 16'h000C;
		run(1'b1, 1'b0, 1'b1, 90);
		c4 = u_drv.cnt[3];
		cw(2700);
		`CHK(dif(u_drv.rise[1], u_drv.rise[2], 90), 30)
		`CHK(dif(u_drv.rise[0], u_drv.rise[1], 90), 30)
		`CHK(u_drv.cnt[3], c4)
		`CHK(act, 4'h7)
		`CHK(chn, 2'h2)
		`CHK(avg, 12'h064)
		`CHK(u_drv.wid[1], 12)
		`CHK(u_drv.wid[0] > 12, 1'b1)
		`CHK(u_drv.wid[2] < 12, 1'b1)
		`CHK({ser, par, bridge}, 3'b010)
		stop();
	endtask : t_three

	task automatic t_two();
		cur = {4{12'h064}};
		amp = 16'h0005;
		c3 = u_drv.cnt[2];
		c4 = u_drv.cnt[3];
		run(1'b0, 1'b1, 1'b0, 40);
		cw(200);
		`CHK(dif(u_drv.rise[1], u_drv.rise[0], 40), 20)
		`CHK(dif(u_drv.rise[0], u_drv.rise[1], 40), 20)
		`CHK(u_drv.cnt[2] - c3 + u_drv.cnt[3] - c4, 0)
		`CHK(act, 4'h3)
		`CHK(chn, 2'h1)
		`CHK(u_drv.wid[1], 5)
		`CHK({ser, bridge}, 2'b11)
		stop();
	endtask : t_two

	task automatic finish_test();
		$display("TB: checks=%0d miscompares=%0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test

	initial begin
		cw(6);
		rst_n = 1'b1;
		cw(2);
		t_four();
		t_three();
		t_two();
		finish_test();
	end
endmodule : tb_mps_sequencer
